// *** rtl/eeprom_slave_defines.vh ***
// Purpose: Shared constants of the two-wire EEPROM slave bit layer
// Assumes: Core clock of 10 MHz
// Notes:   Definitions only
`ifndef EEPROM_SLAVE_DEFINES_VH
`define EEPROM_SLAVE_DEFINES_VH

// Core clock period
`define CLK_PERIOD_NS      100
// glitch_filter_width, low-voltage and higher-voltage ranges
`define GLITCH_LV_NS       100
`define GLITCH_HV_NS       50
// Filter width in cycles, rounded up, at least one; a pulse must last one cycle longer to pass
`define GLITCH_LV_CYC      ((`GLITCH_LV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GLITCH_HV_CYC      ((`GLITCH_HV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W         3
// Byte framing
`define BITS_PER_BYTE      4'h8
`define BIT_CNT_RST        4'h0
// Byte sent when no transmit data is offered
`define TX_FILL_BYTE       8'hff
`define BYTE_RST           8'h00

`endif

// *** rtl/byte_buffer.v ***
// Purpose: Two-entry byte buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Head entry drives the outputs directly from registers
`timescale 1ns/10ps
`include "eeprom_slave_defines.vh"

module byte_buffer
(
   // Clock and reset
   input  wire       ref_clk,
   input  wire       srst,
   // Fill side
   input  wire [7:0] inData,
   input  wire       inValid,
   output wire       inReady,
   // Drain side
   output reg  [7:0] outData_r,
   output reg        outValid_r,
   input  wire       outReady
);

   reg  [7:0] tailData_r;
   reg        tailValid_r;
   wire       push;
   wire       pop;

   // Ready only while the tail slot is free, so a stalled drain fills both
   assign inReady = ~tailValid_r;
   assign push    = inValid & inReady;
   assign pop     = outValid_r & outReady;

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         outData_r   <= `BYTE_RST;
         outValid_r  <= 1'b0;
         tailData_r  <= `BYTE_RST;
         tailValid_r <= 1'b0;
      end
      else
      begin
         if (pop)
         begin
            if (tailValid_r)
            begin
               outData_r   <= tailData_r;
               tailValid_r <= 1'b0;
            end
            else
            begin
               outValid_r <= 1'b0;
            end
         end
         if (push)
         begin
            if (~outValid_r | pop)
            begin
               outData_r  <= inData;
               outValid_r <= 1'b1;
            end
            else
            begin
               tailData_r  <= inData;
               tailValid_r <= 1'b1;
            end
         end
      end
   end

endmodule

// *** rtl/eeprom_two_wire_slave.v ***
// Purpose: Bit and byte layer of a two-wire EEPROM slave with power-on gating
// Assumes: SCL, SDA and the supply monitor are asynchronous to ref_clk
// Notes:   No clock stretching; a byte that cannot be buffered is not acknowledged
// Contract
// R1: Sample SDA on rising SCL, change driven SDA only on falling SCL.
// R2: Bytes move most significant bit first, one bit per SCL clock.
// R3: Every byte takes nine clocks: eight data, one acknowledge.
// R4: After eight bits the receiver answers ACK or NACK in clock nine.
// R5: Master clocks each byte and acknowledge without pauses or skipped clocks.
// R6: SDA changes only while SCL low, steady while SCL high.
// R7: SDA change while SCL high is Start or Stop, not data.
// R8: Any number of bytes between Start and Stop.
// R9: Bus is idle only when SCL and SDA are both high.
// R10: Master initiates and controls every operation; device only responds.
// R11: Reject SCL and SDA pulses shorter than 100 ns or 50 ns.
// R12: Ignore all commands until supply passes power_on_threshold.
// R13: Master waits power_up_wait, 100 us, before first command.
// R14: SDA falling with SCL high is Start, leaving standby.
// R15: SDA rising with SCL high is Stop, ending transfer, back to standby.
// R16: Transmitter releases after eighth clock; receiver drives ACK through ninth.
// R17: Master NACK during a read makes the device release SDA.
// R18: Pins are synchronised, filtered, and edges found on filtered values.
`timescale 1ns/10ps
`include "eeprom_slave_defines.vh"

module eeprom_two_wire_slave
(
   // Clock and reset
   input  wire       ref_clk,
   input  wire       srst,
   // Power-on comparator, high once supply is above power_on_threshold
   input  wire       supplyAboveThreshold,
   // Filter range select, high for the higher-voltage range
   input  wire       highVoltageRange,
   // Two-wire pins
   input  wire       sclIn,
   input  wire       sdaIn,
   output reg        sdaOut_r,
   output reg        sdaOe_r,
   // Received bytes
   output wire [7:0] rxData,
   output wire       rxValid,
   input  wire       rxReady,
   // Transmit control and data
   input  wire       ackEnable,
   input  wire       txMode,
   input  wire [7:0] txData,
   input  wire       txValid,
   output reg        txTaken_r,
   // Bus events and status
   output reg        startSeen_r,
   output reg        stopSeen_r,
   output reg        masterNack_r,
   output reg        rxOverrun_r,
   output reg        active_r,
   output reg        busIdle_r
);

   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_RX   = 6'b000010;
   localparam [5:0] ST_ACKO = 6'b000100;
   localparam [5:0] ST_TX   = 6'b001000;
   localparam [5:0] ST_ACKI = 6'b010000;
   localparam [5:0] ST_HOLD = 6'b100000;

   reg  [2:0]              meta_r;
   reg  [2:0]              sync_r;
   wire [1:0]              filt;
   reg                     sclPrev_r;
   reg                     sdaPrev_r;
   reg  [5:0]              state_r;
   reg  [3:0]              bitCnt_r;
   reg  [7:0]              rxShift_r;
   reg  [7:0]              txShift_r;
   reg                     pushValid_r;
   reg  [7:0]              pushData_r;
   wire                    pushReady;
   wire [31:0]             limitWide;
   wire [`FILT_CNT_W-1:0]  filtLimit;
   wire                    sclF;
   wire                    sdaF;
   wire                    sclRise;
   wire                    sclFall;
   wire                    startCond;
   wire                    stopCond;
   wire                    powered;
   // Two flops per pin before any logic looks at it [R18]
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_r <= 3'h7;
         sync_r <= 3'h7;
      end
      else
      begin
         meta_r <= {supplyAboveThreshold, sdaIn, sclIn};
         sync_r <= meta_r;
      end
   end

   assign limitWide = highVoltageRange ? `GLITCH_HV_CYC : `GLITCH_LV_CYC;
   assign filtLimit = limitWide[`FILT_CNT_W-1:0];

   // A new level must persist beyond the filter width before it is taken [R11] [R18]
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_filt
         reg                    level_r;
         reg [`FILT_CNT_W-1:0]  cnt_r;
         always @(posedge ref_clk)
         begin
            if (srst)
            begin
               level_r <= 1'b1;
               cnt_r   <= {`FILT_CNT_W{1'b0}};
            end
            else if (sync_r[i] == level_r)
               cnt_r <= {`FILT_CNT_W{1'b0}};
            else if (cnt_r >= filtLimit)
            begin
               level_r <= sync_r[i];
               cnt_r   <= {`FILT_CNT_W{1'b0}};
            end
            else
               cnt_r <= cnt_r + 1'b1;
         end
         assign filt[i] = level_r;
      end
   endgenerate

   assign sclF      = filt[0];
   assign sdaF      = filt[1];
   assign powered   = sync_r[2];
   assign sclRise   = sclF & ~sclPrev_r;
   assign sclFall   = ~sclF & sclPrev_r;
   // SDA moving while SCL stays high is never data [R7]
   assign startCond = sclF & sclPrev_r & sdaPrev_r & ~sdaF; // [R14]
   assign stopCond  = sclF & sclPrev_r & ~sdaPrev_r & sdaF; // [R15]
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         sclPrev_r    <= 1'b1;
         sdaPrev_r    <= 1'b1;
         state_r      <= ST_IDLE;
         bitCnt_r     <= `BIT_CNT_RST;
         rxShift_r    <= `BYTE_RST;
         txShift_r    <= `TX_FILL_BYTE;
         pushValid_r  <= 1'b0;
         pushData_r   <= `BYTE_RST;
         sdaOut_r     <= 1'b0;
         sdaOe_r      <= 1'b0;
         txTaken_r    <= 1'b0;
         startSeen_r  <= 1'b0;
         stopSeen_r   <= 1'b0;
         masterNack_r <= 1'b0;
         rxOverrun_r  <= 1'b0;
         active_r     <= 1'b0;
         busIdle_r    <= 1'b0;
      end
      else
      begin
         sclPrev_r    <= sclF;
         sdaPrev_r    <= sdaF;
         pushValid_r  <= 1'b0;
         txTaken_r    <= 1'b0;
         startSeen_r  <= 1'b0;
         stopSeen_r   <= 1'b0;
         masterNack_r <= 1'b0;
         rxOverrun_r  <= 1'b0;
         busIdle_r    <= sclF & sdaF & state_r[0]; // [R9]
         active_r     <= ~state_r[0];
         if (~powered)
         begin
            // Held in power-on reset: the bus is ignored and SDA released [R12]
            state_r  <= ST_IDLE;
            bitCnt_r <= `BIT_CNT_RST;
            sdaOe_r  <= 1'b0;
         end
         else if (startCond)
         begin
            // Also a repeated Start in the middle of a transfer [R14]
            state_r     <= ST_RX;
            bitCnt_r    <= `BIT_CNT_RST;
            sdaOe_r     <= 1'b0;
            startSeen_r <= 1'b1;
         end
         else if (stopCond)
         begin
            state_r    <= ST_IDLE; // [R15]
            bitCnt_r   <= `BIT_CNT_RST;
            sdaOe_r    <= 1'b0;
            stopSeen_r <= ~state_r[0];
         end
         else
         begin
            case (state_r)
               ST_RX:
               begin
                  if (sclRise)
                  begin
                     rxShift_r <= {rxShift_r[6:0], sdaF}; // [R1] [R2]
                     bitCnt_r  <= bitCnt_r + 1'b1;
                  end
                  else if (sclFall && bitCnt_r == `BITS_PER_BYTE)
                  begin
                     // Ack only a byte the buffer can take, else leave SDA high [R4] [R16]
                     state_r     <= ST_ACKO;
                     bitCnt_r    <= `BIT_CNT_RST;
                     sdaOe_r     <= ackEnable & pushReady;
                     pushValid_r <= ackEnable & pushReady;
                     pushData_r  <= rxShift_r;
                     rxOverrun_r <= ackEnable & ~pushReady;
                  end
               end
               ST_ACKO:
               begin
                  if (sclFall)
                  begin
                     // Ninth clock over: release, or start the next byte out [R3] [R16]
                     if (txMode)
                     begin
                        state_r   <= ST_TX;
                        txTaken_r <= txValid;
                        txShift_r <= txValid ? {txData[6:0], 1'b1}
                                             : {`TX_FILL_BYTE};
                        sdaOe_r   <= txValid ? ~txData[7] : 1'b0; // [R2] [R6]
                     end
                     else
                     begin
                        state_r <= ST_RX;
                        sdaOe_r <= 1'b0;
                     end
                  end
               end
               ST_TX:
               begin
                  if (sclRise)
                     bitCnt_r <= bitCnt_r + 1'b1;
                  else if (sclFall)
                  begin
                     if (bitCnt_r == `BITS_PER_BYTE)
                     begin
                        // Release after the eighth clock for the master's answer [R16]
                        state_r  <= ST_ACKI;
                        bitCnt_r <= `BIT_CNT_RST;
                        sdaOe_r  <= 1'b0;
                     end
                     else
                     begin
                        sdaOe_r   <= ~txShift_r[7]; // [R1] [R6]
                        txShift_r <= {txShift_r[6:0], 1'b1};
                     end
                  end
               end
               ST_ACKI:
               begin
                  if (sclRise && sdaF)
                  begin
                     // Master is done reading; SDA stays released for its Stop [R17]
                     state_r      <= ST_HOLD;
                     masterNack_r <= 1'b1;
                  end
                  else if (sclFall)
                  begin
                     // Acknowledged: next byte follows with no spare clock [R5] [R8]
                     state_r   <= ST_TX;
                     txTaken_r <= txValid;
                     txShift_r <= txValid ? {txData[6:0], 1'b1}
                                          : {`TX_FILL_BYTE};
                     sdaOe_r   <= txValid ? ~txData[7] : 1'b0;
                  end
               end
               ST_HOLD:
                  sdaOe_r <= 1'b0;
               default:
               begin
                  state_r <= ST_IDLE;
                  sdaOe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   byte_buffer i_byte_buffer
   (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .inData     (pushData_r),
      .inValid    (pushValid_r),
      .inReady    (pushReady),
      .outData_r  (rxData),
      .outValid_r (rxValid),
      .outReady   (rxReady)
   );
endmodule

// *** verif/eeprom_two_wire_slave_asserts.sv ***
// Purpose: Port-level checks of the two-wire slave
// Assumes: Bench SCL low 600 ns, high 200 ns
// Notes:   Bound to the slave at the foot of this file
`timescale 1ns/10ps
module eeprom_two_wire_slave_asserts
(
   // Clock and reset
   input wire       ref_clk,
   input wire       srst,
   // Watched ports
   input wire       supplyAboveThreshold,
   input wire       sclIn,
   input wire       sdaIn,
   input wire       sdaOut_r,
   input wire       sdaOe_r,
   input wire [7:0] rxData,
   input wire       rxValid,
   input wire       rxReady,
   input wire       txTaken_r,
   input wire       startSeen_r,
   input wire       stopSeen_r,
   input wire       masterNack_r,
   input wire       rxOverrun_r,
   input wire       busIdle_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence supplyLow;
      (!supplyAboveThreshold)[*6];
   endsequence
   sequence linesBusy;
      (!sclIn || !sdaIn)[*6];
   endsequence
   a_open_drain: assert property (sdaOe_r |-> !sdaOut_r)
      else $error("SDA driven high");
   a_supply_gate: assert property (supplyLow |-> !startSeen_r && !sdaOe_r)
      else $error("Activity while supply low");
   a_oe_scl_low: assert property ($changed(sdaOe_r) |-> !sclIn)
      else $error("SDA drive changed with SCL high");
   a_start_lines: assert property (startSeen_r |-> sclIn && !sdaIn)
      else $error("Start without SDA low under SCL high");
   a_stop_idle: assert property (stopSeen_r |-> sclIn && sdaIn ##[1:4] busIdle_r)
      else $error("Stop not followed by idle");
   a_idle_quiet: assert property (linesBusy |-> !busIdle_r)
      else $error("Idle while a line is low");
   a_overrun_nack: assert property (rxOverrun_r |-> rxValid ##1 (!sdaOe_r)[*4])
      else $error("Overrun byte acknowledged");
   a_nack_release: assert property (masterNack_r |-> (!sdaOe_r)[*8])
      else $error("SDA held after master NACK");
   a_tx_on_fall: assert property (txTaken_r |-> !sclIn)
      else $error("Transmit byte taken with SCL high");
   a_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
      else $error("Buffered byte lost");
endmodule
bind eeprom_two_wire_slave eeprom_two_wire_slave_asserts i_eeprom_two_wire_slave_asserts
(
   .ref_clk(ref_clk), .srst(srst), .supplyAboveThreshold(supplyAboveThreshold),
   .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut_r(sdaOut_r), .sdaOe_r(sdaOe_r),
   .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .txTaken_r(txTaken_r),
   .startSeen_r(startSeen_r), .stopSeen_r(stopSeen_r), .masterNack_r(masterNack_r),
   .rxOverrun_r(rxOverrun_r), .busIdle_r(busIdle_r)
);

// *** verif/i2c_master_model.sv ***
// Purpose: Bus master driving SCL and pulling SDA low
// Assumes: SCL period 800 ns, low 600 ns, high 200 ns
// Notes:   Long low phase leaves room for the slave's filter latency
`timescale 1ns/10ps
module i2c_master_model
(
   // Clock and wires
   input  wire ref_clk,
   input  wire sdaWire,
   output reg  scl,
   output reg  sdaLow
);
   initial
   begin
      scl = 1'h1;
      sdaLow = 1'h0;
   end
   task tick(input integer n);
   begin
      repeat (n) @(posedge ref_clk);
      #1;
   end
   endtask
   task start;
   begin
      sdaLow = 1'h0;
      tick(6);
      scl = 1'h1;
      tick(8);
      sdaLow = 1'h1;
      tick(8);
      scl = 1'h0;
   end
   endtask
   task stop;
   begin
      tick(1);
      sdaLow = 1'h1;
      tick(6);
      scl = 1'h1;
      tick(8);
      sdaLow = 1'h0;
      tick(8);
   end
   endtask
   // SDA moves one cycle after the fall, so it never moves under SCL high
   task clk9(input b, output s);
   begin
      tick(1);
      sdaLow = !b;
      tick(5);
      scl = 1'h1;
      tick(1);
      s = sdaWire;
      tick(1);
      scl = 1'h0;
   end
   endtask
   task xfer(input [7:0] d, input ackIn, output [7:0] q, output ack);
      integer i;
   begin
      for (i = 7; i >= 0; i = i - 1)
         clk9(d[i], q[i]);
      clk9(ackIn, ack);
   end
   endtask
   // A single-cycle spike on one line while the other stays high
   task spike(input onScl);
   begin
      if (onScl)
         scl = 1'h0;
      else
         sdaLow = 1'h1;
      tick(1);
      scl = 1'h1;
      sdaLow = 1'h0;
      tick(12);
   end
   endtask
endmodule

// *** verif/tb_eeprom_two_wire_slave.sv ***
// Purpose: Self-checking bench of the two-wire slave
// Assumes: 10 MHz core clock, 800 ns SCL
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tb_eeprom_two_wire_slave;
   reg        ref_clk, srst, supplyAboveThreshold, highVoltageRange;
   reg        rxReady, ackEnable, txMode, txValid, ack;
   reg  [7:0] txData, q;
   wire       scl, mSdaLow, sdaOut_r, sdaOe_r, rxValid, txTaken_r, startSeen_r, stopSeen_r;
   wire       masterNack_r, rxOverrun_r, active_r, busIdle_r;
   wire [7:0] rxData;
   integer    n_errors = 0, checks = 0, nStart = 0, nStop = 0, nNack = 0, nTaken = 0, nOver = 0;
   // power_up_wait of 100 us in 100 ns cycles
   localparam integer POWER_UP_WAIT_CYC = 1000;
   // Pull-up on SDA; either party may pull it low
   wire       sdaWire = !mSdaLow && (sdaOe_r ? sdaOut_r : 1'h1);
   eeprom_two_wire_slave i_eeprom_two_wire_slave
   (
      .ref_clk(ref_clk), .srst(srst), .supplyAboveThreshold(supplyAboveThreshold),
      .highVoltageRange(highVoltageRange), .sclIn(scl), .sdaIn(sdaWire),
      .sdaOut_r(sdaOut_r), .sdaOe_r(sdaOe_r), .rxData(rxData), .rxValid(rxValid),
      .rxReady(rxReady), .ackEnable(ackEnable), .txMode(txMode), .txData(txData),
      .txValid(txValid), .txTaken_r(txTaken_r), .startSeen_r(startSeen_r),
      .stopSeen_r(stopSeen_r), .masterNack_r(masterNack_r), .rxOverrun_r(rxOverrun_r),
      .active_r(active_r), .busIdle_r(busIdle_r)
   );
   i2c_master_model i_i2c_master_model
   (
      .ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(mSdaLow)
   );
   initial
   begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      nStart = nStart + (startSeen_r === 1'h1);
      nStop = nStop + (stopSeen_r === 1'h1);
      nNack = nNack + (masterNack_r === 1'h1);
      nTaken = nTaken + (txTaken_r === 1'h1);
      nOver = nOver + (rxOverrun_r === 1'h1);
   end
   task tick(input integer n);
   begin
      repeat (n) @(posedge ref_clk);
      #1;
   end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task pop(input [7:0] exp);
      integer i;
   begin
      for (i = 0; i < 50 && rxValid !== 1'h1; i = i + 1)
         tick(1);
      chk({7'h0, rxValid}, 8'h01);
      chk(rxData, exp);
      rxReady = 1'h1;
      tick(1);
      // Let an edge pass so a following pop never re-raises ready in this step
      rxReady = 1'h0;
      tick(1);
   end
   endtask
   task test_supply;
   begin
      supplyAboveThreshold = 1'h0;
      tick(8);
      i_i2c_master_model.start;
      i_i2c_master_model.xfer(8'ha0, 1'h1, q, ack);
      i_i2c_master_model.stop;
      chk({7'h0, ack}, 8'h01);
      chk(nStart[7:0], 8'h00);
      chk({7'h0, rxValid}, 8'h00);
      supplyAboveThreshold = 1'h1;
      tick(POWER_UP_WAIT_CYC);
      $display("test_supply done");
   end
   endtask
   task test_fill;
   begin
      i_i2c_master_model.start;
      chk({7'h0, active_r}, 8'h01);
      i_i2c_master_model.xfer(8'ha0, 1'h1, q, ack);
      chk({7'h0, ack}, 8'h00);
      i_i2c_master_model.xfer(8'h5a, 1'h1, q, ack);
      chk({7'h0, ack}, 8'h00);
      i_i2c_master_model.xfer(8'h96, 1'h1, q, ack);
      chk({7'h0, ack}, 8'h01);
      i_i2c_master_model.stop;
      chk({7'h0, active_r}, 8'h00);
      pop(8'ha0);
      pop(8'h5a);
      chk({7'h0, rxValid}, 8'h00);
      chk(nOver[7:0], 8'h01);
      chk(nStart[7:0], 8'h01);
      chk(nStop[7:0], 8'h01);
      $display("test_fill done");
   end
   endtask
   task test_read;
   begin
      txMode = 1'h1;
      i_i2c_master_model.start;
      i_i2c_master_model.xfer(8'ha1, 1'h1, q, ack);
      chk({7'h0, ack}, 8'h00);
      i_i2c_master_model.xfer(8'hff, 1'h0, q, ack);
      chk(q, 8'h3c);
      // Fresh byte offered after the first is taken, before the next ACK clock ends
      txData = 8'hc3;
      i_i2c_master_model.xfer(8'hff, 1'h0, q, ack);
      chk(q, 8'hc3);
      // Nothing offered: the device must leave SDA released
      txValid = 1'h0;
      i_i2c_master_model.xfer(8'hff, 1'h1, q, ack);
      chk(q, 8'hff);
      i_i2c_master_model.stop;
      txMode = 1'h0;
      txValid = 1'h1;
      chk(nNack[7:0], 8'h01);
      chk(nTaken[7:0], 8'h02);
      pop(8'ha1);
      $display("test_read done");
   end
   endtask
   task test_spike;
      integer hv;
   begin
      for (hv = 0; hv < 2; hv = hv + 1)
      begin
         highVoltageRange = hv[0];
         i_i2c_master_model.spike(1'h0);
         i_i2c_master_model.spike(1'h1);
      end
      // Counts run from the start: one Start and one Stop each in fill and read
      chk(nStart[7:0], 8'h02);
      chk(nStop[7:0], 8'h02);
      chk({7'h0, busIdle_r}, 8'h01);
      $display("test_spike done");
   end
   endtask
   task test_noack;
   begin
      ackEnable = 1'h0;
      i_i2c_master_model.start;
      i_i2c_master_model.xfer(8'h33, 1'h1, q, ack);
      i_i2c_master_model.stop;
      chk({7'h0, ack}, 8'h01);
      chk({7'h0, rxValid}, 8'h00);
      $display("test_noack done");
   end
   endtask
   task final_report;
   begin
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   initial
   begin
      srst = 1'h1;
      supplyAboveThreshold = 1'h1;
      highVoltageRange = 1'h0;
      rxReady = 1'h0;
      ackEnable = 1'h1;
      txMode = 1'h0;
      txValid = 1'h1;
      txData = 8'h3c;
      tick(16);
      srst = 1'h0;
      tick(8);
      test_supply;
      test_fill;
      test_read;
      test_spike;
      test_noack;
      final_report;
   end
   // Whole run is near 2000 cycles with the power-up wait; ten times that is a hang
   initial
   begin
      #2000000;
      n_errors = n_errors + 1;
      final_report;
   end
endmodule
